// file: hdl/smbevt_core.v
// SMBus event routing, host CRC and target-side decoder
`timescale 1ns/1ps
`default_nettype none
`include "smbevt_map.vh"
// Notes on behaviour
// - Alert low always wakes, sets status bit 5; routes SMI or interrupt per enables.
// - Wake/SMI command wakes when asleep, else secondary SMI with status.
// - Link-target SMI command raises secondary SMI only in S0; status is set in any state.
// - Host status bits 4..1: none, interrupt, or host SMI per two enables.
// - Host Notify: wake per wake enable; interrupt or SMI per enables.
// - Auto CRC appends computed CRC on writes, checks it on reads.
// - Auto CRC sends computed value, never the software packet-error register.
// - Read CRC mismatch sets device error and CRC error at 0Ch.
// - Target logic neither generates nor checks packet-error bytes.
// - Target decodes Byte Write and Host Notify; a read address is only acknowledged.
// - Own target address resets to a usable default.
// - Data bytes written to target registers 04h and 05h land in processor-readable receive registers.
// - Match sets notify status bit 0 or SMI status bit 0.
// - Every satisfied enable combination produces its result together.
module smbevt_core (
	input  wire       sys_clk_in,
	input  wire       reset_in,
	input  wire       clk_en_in,
	input  wire       io_wr_in,
	input  wire       io_rd_in,
	input  wire [7:0] io_addr_in,
	input  wire [7:0] io_wdata_in,
	output reg  [7:0] io_rdata_out,
	input  wire       alert_n_in,
	input  wire [3:0] host_evt_in,
	input  wire       system_awake_in,
	input  wire       system_s0_in,
	input  wire       crc_byte_in,
	input  wire [7:0] crc_data_in,
	input  wire       crc_clear_in,
	input  wire       crc_tx_last_in,
	input  wire       crc_rx_check_in,
	input  wire [7:0] crc_rx_byte_in,
	output reg  [7:0] crc_tx_byte_out,
	output reg        crc_tx_valid_out,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe_out,
	output reg        wake_out,
	output wire       intr_out,
	output wire       host_smi_out,
	output reg        target_smi_out
);
	reg  [7:0] host_ctl_q;
	reg  [7:0] aux_sts_q;
	reg  [7:0] tgt_ctl_q;
	reg  [7:0] host_cfg_q;
	reg  [7:0] host_sts_q;
	reg  [7:0] aux_ctl_q;
	reg  [7:0] pec_q;
	reg  [6:0] own_target_address_q;
	reg  [7:0] tgt_data0_q, tgt_data1_q, tgt_cmd_q;
	reg        notify_sts_q, target_smi_status_q;
	reg  [7:0] crc_q;
	reg  [1:0] scl_s_q, sda_s_q;
	reg        scl_d_q, sda_d_q;
	reg  [3:0] bit_cnt_q;
	reg  [7:0] shift_q;
	reg  [1:0] byte_idx_q;
	reg        active_q;
	reg        matched_q;
	reg        is_read_q;
	reg        is_notify_q;
	reg        ack_q;
	reg  [7:0] reg_sel_q;
	reg        msg_done_q;
	wire       host_intr_enable    = host_ctl_q[`SMBEVT_BIT_INTR_EN];
	wire       smi_route_enable    = host_cfg_q[`SMBEVT_BIT_SMI_ROUTE];
	wire       alert_input_disable = tgt_ctl_q[`SMBEVT_BIT_ALERT_DIS];
	wire       notify_intr_enable  = tgt_ctl_q[`SMBEVT_BIT_NOTIFY_INTR];
	wire       notify_wake_enable  = tgt_ctl_q[`SMBEVT_BIT_NOTIFY_WAKE];
	wire       auto_crc_enable     = aux_ctl_q[`SMBEVT_BIT_AUTO_CRC];
	reg  [1:0] alert_s_q;
	wire       alert_act = ~alert_s_q[1];
	wire       scl_v = scl_s_q[1];
	wire       sda_v = sda_s_q[1];
	wire       start_c = scl_v & scl_d_q & sda_d_q & ~sda_v;
	wire       stop_c  = scl_v & scl_d_q & ~sda_d_q & sda_v;
	wire       scl_rise = scl_v & ~scl_d_q;
	wire       scl_fall = ~scl_v & scl_d_q;
	wire       wr_hit = io_wr_in & clk_en_in;
	wire       rd_hit = io_rd_in & clk_en_in;
	wire [7:0] crc_next;
	wire       host_any = |host_sts_q[4:1];
	// Target-side event pulses
	wire       ev_wake_cmd = msg_done_q & ~is_notify_q & (reg_sel_q == `SMBEVT_TREG_CMD)
		& (tgt_cmd_q == `SMBEVT_CMD_WAKE_SMI);
	wire       ev_link_cmd = msg_done_q & ~is_notify_q & (reg_sel_q == `SMBEVT_TREG_CMD)
		& (tgt_cmd_q == `SMBEVT_CMD_LINK_SMI);
	wire       ev_notify = msg_done_q & is_notify_q;
	wire       ev_alert_smi = alert_act & smi_route_enable & ~alert_input_disable;
	wire       ev_sec_smi = (ev_wake_cmd & system_awake_in)
		| (ev_link_cmd & system_s0_in)
		| (ev_notify & notify_intr_enable & smi_route_enable);
	wire       tsmi_set = ev_sec_smi | ev_alert_smi | (msg_done_q & ~is_notify_q);
	// Interrupt and host SMI outputs, every satisfied combination together
	assign intr_out = (host_any & host_intr_enable & ~smi_route_enable)
		| (alert_act & host_intr_enable & ~smi_route_enable & ~alert_input_disable)
		| (notify_sts_q & notify_intr_enable & ~smi_route_enable);
	assign host_smi_out = host_any & host_intr_enable & smi_route_enable;
	// Target only acknowledges; never drives a packet-error byte
	assign sda_out = 1'b0;
	assign sda_oe_out = ack_q;
	// Bitwise CRC-8 over one byte
	function [7:0] crc8;
		input [7:0] c;
		input [7:0] d;
		integer i;
		reg [7:0] r;
		begin
			r = c ^ d;
			for (i = 0; i < 8; i = i + 1) begin
				r = r[7] ? ((r << 1) ^ `SMBEVT_CRC_POLY) : (r << 1);
			end
			crc8 = r;
		end
	endfunction
	assign crc_next = crc8(crc_q, crc_data_in);
	// Input synchronisers and edge history
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			alert_s_q <= 2'h3;
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else if (clk_en_in) begin
			alert_s_q <= {alert_s_q[0], alert_n_in};
			scl_s_q <= {scl_s_q[0], scl_in};
			sda_s_q <= {sda_s_q[0], sda_in};
			scl_d_q <= scl_v;
			sda_d_q <= sda_v;
		end
	end
	// Host CRC and software registers
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			host_ctl_q <= 8'h00;
			aux_sts_q <= 8'h00;
			tgt_ctl_q <= 8'h00;
			host_cfg_q <= 8'h00;
			host_sts_q <= 8'h00;
			aux_ctl_q <= 8'h00;
			pec_q <= 8'h00;
			own_target_address_q <= `SMBEVT_RST_TGT_ADDR;
			crc_q <= 8'h00;
			crc_tx_byte_out <= 8'h00;
			crc_tx_valid_out <= 1'b0;
			notify_sts_q <= 1'b0;
			target_smi_status_q <= 1'b0;
			wake_out <= 1'b0;
			target_smi_out <= 1'b0;
		end else if (clk_en_in) begin
			crc_tx_valid_out <= 1'b0;
			if (wr_hit) begin
				case (io_addr_in)
				`SMBEVT_OFF_HOST_CTL: host_ctl_q <= io_wdata_in;
				`SMBEVT_OFF_TGT_CTL:  tgt_ctl_q <= io_wdata_in;
				`SMBEVT_OFF_HOST_CFG: host_cfg_q <= io_wdata_in;
				`SMBEVT_OFF_AUX_CTL:  aux_ctl_q <= io_wdata_in;
				`SMBEVT_OFF_TGT_ADDR: own_target_address_q <= io_wdata_in[6:0];
				`SMBEVT_OFF_PEC:      pec_q <= io_wdata_in;
				default: ;
				endcase
			end
			// Write-one-to-clear status; a same-cycle set wins
			if (wr_hit && io_addr_in == `SMBEVT_OFF_HOST_STS)
				host_sts_q <= (host_sts_q & ~io_wdata_in) | {2'h0, alert_act, host_evt_in, 1'b0};
			else
				host_sts_q <= host_sts_q | {2'h0, alert_act, host_evt_in, 1'b0};
			if (wr_hit && io_addr_in == `SMBEVT_OFF_AUX_STS)
				aux_sts_q <= aux_sts_q & ~io_wdata_in;
			if (crc_clear_in)
				crc_q <= 8'h00;
			else if (crc_byte_in && auto_crc_enable)
				crc_q <= crc_next;
			if (crc_tx_last_in) begin
				crc_tx_byte_out <= auto_crc_enable ? crc_q : pec_q;
				crc_tx_valid_out <= 1'b1;
			end
			if (crc_rx_check_in && auto_crc_enable && crc_rx_byte_in != crc_q) begin
				aux_sts_q[`SMBEVT_BIT_DEVICE_ERROR_FLAG] <= 1'b1;
				aux_sts_q[`SMBEVT_BIT_CRC_ERR] <= 1'b1;
			end
			if (wr_hit && io_addr_in == `SMBEVT_OFF_TGT_STS && io_wdata_in[0])
				notify_sts_q <= ev_notify;
			else if (ev_notify)
				notify_sts_q <= 1'b1;
			if (wr_hit && io_addr_in == `SMBEVT_OFF_SMI_STS && io_wdata_in[0])
				target_smi_status_q <= tsmi_set;
			else if (tsmi_set)
				target_smi_status_q <= 1'b1;
			wake_out <= alert_act | (ev_wake_cmd & ~system_awake_in)
				| (ev_notify & notify_wake_enable);
			target_smi_out <= ev_sec_smi | ev_alert_smi;
		end
	end
	// Target-side byte decoder
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			byte_idx_q <= 2'h0;
			active_q <= 1'b0;
			matched_q <= 1'b0;
			is_read_q <= 1'b0;
			is_notify_q <= 1'b0;
			ack_q <= 1'b0;
			reg_sel_q <= 8'h00;
			tgt_cmd_q <= 8'h00;
			tgt_data0_q <= 8'h00;
			tgt_data1_q <= 8'h00;
			msg_done_q <= 1'b0;
		end else if (clk_en_in) begin
			msg_done_q <= 1'b0;
			if (start_c) begin
				active_q <= 1'b1;
				bit_cnt_q <= 4'h0;
				byte_idx_q <= 2'h0;
				matched_q <= 1'b0;
				ack_q <= 1'b0;
			end else if (stop_c) begin
				active_q <= 1'b0;
				ack_q <= 1'b0;
				msg_done_q <= matched_q & ~is_read_q & (byte_idx_q == 2'h3);
			end else if (active_q && scl_rise && bit_cnt_q < 4'h8) begin
				shift_q <= {shift_q[6:0], sda_v};
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end else if (active_q && scl_fall && bit_cnt_q == 4'h8) begin
				// Address byte: match and direction
				if (byte_idx_q == 2'h0) begin
					is_read_q <= shift_q[0];
					is_notify_q <= shift_q[7:1] == `SMBEVT_NOTIFY_ADDR;
					matched_q <= (shift_q[7:1] == own_target_address_q)
						| (shift_q[7:1] == `SMBEVT_NOTIFY_ADDR & ~shift_q[0]);
					ack_q <= (shift_q[7:1] == own_target_address_q)
						| (shift_q[7:1] == `SMBEVT_NOTIFY_ADDR & ~shift_q[0]);
				end else if (matched_q && !is_read_q) begin
					ack_q <= 1'b1;
					if (byte_idx_q == 2'h1)
						reg_sel_q <= shift_q;
					if (byte_idx_q == 2'h2) begin
						if (is_notify_q) begin
							tgt_data0_q <= reg_sel_q;
							tgt_data1_q <= shift_q;
						end
						if (!is_notify_q && reg_sel_q == `SMBEVT_TREG_CMD)
							tgt_cmd_q <= shift_q;
						if (!is_notify_q && reg_sel_q == `SMBEVT_TREG_DATA0)
							tgt_data0_q <= shift_q;
						if (!is_notify_q && reg_sel_q == `SMBEVT_TREG_DATA1)
							tgt_data1_q <= shift_q;
					end
				end else
					ack_q <= 1'b0;
				if (byte_idx_q != 2'h3)
					byte_idx_q <= byte_idx_q + 2'h1;
				bit_cnt_q <= 4'h9;
			end else if (active_q && scl_fall && bit_cnt_q == 4'h9) begin
				ack_q <= 1'b0;
				bit_cnt_q <= 4'h0;
				if (!is_notify_q && byte_idx_q == 2'h3)
					byte_idx_q <= 2'h3;
			end
			if (stop_c && matched_q && !is_read_q && !is_notify_q && byte_idx_q == 2'h3)
				msg_done_q <= 1'b1;
		end
	end
	// Register read mux
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			io_rdata_out <= 8'h00;
		else if (rd_hit) begin
			case (io_addr_in)
			`SMBEVT_OFF_HOST_STS:  io_rdata_out <= host_sts_q;
			`SMBEVT_OFF_HOST_CTL:  io_rdata_out <= host_ctl_q;
			`SMBEVT_OFF_AUX_STS:   io_rdata_out <= aux_sts_q;
			`SMBEVT_OFF_AUX_CTL:   io_rdata_out <= aux_ctl_q;
			`SMBEVT_OFF_TGT_CTL:   io_rdata_out <= tgt_ctl_q;
			`SMBEVT_OFF_HOST_CFG:  io_rdata_out <= host_cfg_q;
			`SMBEVT_OFF_TGT_ADDR:  io_rdata_out <= {1'b0, own_target_address_q};
			`SMBEVT_OFF_PEC:       io_rdata_out <= pec_q;
			`SMBEVT_OFF_TGT_DATA0: io_rdata_out <= tgt_data0_q;
			`SMBEVT_OFF_TGT_DATA1: io_rdata_out <= tgt_data1_q;
			`SMBEVT_OFF_TGT_STS:   io_rdata_out <= {7'h00, notify_sts_q};
			`SMBEVT_OFF_SMI_STS:   io_rdata_out <= {7'h00, target_smi_status_q};
			default:               io_rdata_out <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: include/smbevt_map.vh
// Register offsets, field positions and reset values for the SMBus event block
`ifndef SMBEVT_MAP_VH
`define SMBEVT_MAP_VH
`define SMBEVT_OFF_HOST_CTL      8'h02
`define SMBEVT_OFF_AUX_STS       8'h0c
`define SMBEVT_OFF_TGT_CTL       8'h11
`define SMBEVT_OFF_HOST_CFG      8'h40
`define SMBEVT_OFF_HOST_STS      8'h00
`define SMBEVT_OFF_AUX_CTL       8'h0d
`define SMBEVT_OFF_TGT_ADDR      8'h09
`define SMBEVT_OFF_TGT_DATA0     8'h0a
`define SMBEVT_OFF_TGT_DATA1     8'h0b
`define SMBEVT_OFF_TGT_STS       8'h10
`define SMBEVT_OFF_SMI_STS       8'h12
`define SMBEVT_OFF_PEC           8'h05
`define SMBEVT_BIT_INTR_EN       0
`define SMBEVT_BIT_SMI_ROUTE     1
`define SMBEVT_BIT_ALERT_DIS     2
`define SMBEVT_BIT_NOTIFY_INTR   0
`define SMBEVT_BIT_NOTIFY_WAKE   1
`define SMBEVT_BIT_ALERT_STS     5
`define SMBEVT_BIT_DEVICE_ERROR_FLAG       2
`define SMBEVT_BIT_CRC_ERR       0
`define SMBEVT_BIT_AUTO_CRC      0
`define SMBEVT_BIT_NOTIFY_STS    0
`define SMBEVT_BIT_TGT_SMI_STS   0
`define SMBEVT_RST_TGT_ADDR      7'h44
`define SMBEVT_CMD_WAKE_SMI      8'h01
`define SMBEVT_CMD_LINK_SMI      8'h08
`define SMBEVT_TREG_CMD          8'h00
`define SMBEVT_TREG_DATA0        8'h04
`define SMBEVT_TREG_DATA1        8'h05
`define SMBEVT_NOTIFY_ADDR       7'h08
`define SMBEVT_CRC_POLY          8'h07
`endif

// file: tb/smbevt_core_tb.sv
// Testbench for the SMBus event block
`timescale 1ns/1ps
`default_nettype none
module smbevt_core_tb;
	logic       clk, ce, rst, wr, rd, alert_n, awake, s0, cb, cclr, clast, cchk;
	logic [7:0] addr, wdata, cdata, crx, rdata, tbyte;
	logic [3:0] evt;
	logic       tvalid, scl, sda, sda_o, sda_oe, wake, intr, hsmi, tsmi;
	int         n_errors, compares;
	smbevt_core smbevt_core_i (.sys_clk_in(clk), .reset_in(rst), .clk_en_in(ce),
		.io_wr_in(wr), .io_rd_in(rd), .io_addr_in(addr), .io_wdata_in(wdata),
		.io_rdata_out(rdata), .alert_n_in(alert_n), .host_evt_in(evt), .system_awake_in(awake),
		.system_s0_in(s0), .crc_byte_in(cb), .crc_data_in(cdata), .crc_clear_in(cclr),
		.crc_tx_last_in(clast), .crc_rx_check_in(cchk), .crc_rx_byte_in(crx),
		.crc_tx_byte_out(tbyte), .crc_tx_valid_out(tvalid), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_out(sda_oe), .wake_out(wake), .intr_out(intr),
		.host_smi_out(hsmi), .target_smi_out(tsmi));
	smbevt_mcu smbevt_mcu_i (.sda_oe_in(sda_oe), .scl_out(scl), .sda_line_out(sda));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = !clk;
	end
	task automatic chk(input string w, input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic test_done;
		if (n_errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic watch(output logic [2:0] s);
		s = 3'b000;
		repeat (280) begin
			@(posedge clk);
			#1 s = s | {wake, intr, tsmi};
		end
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, d);
		c = c ^ d;
		for (int k = 0; k < 8; k++) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
		return c;
	endfunction
	task automatic t_alert;
		logic [7:0] d;
		rd_reg(8'h09, d);
		chk("own address", d, 8'h44);
		rd_reg(8'h33, d);
		chk("unmapped", d, 8'h00);
		wr_reg(8'h02, 8'h01);
		@(posedge clk) alert_n <= 1'b0;
		repeat (8) @(posedge clk);
		#1 chk("alert out", {5'h00, wake, intr, hsmi}, 8'h06);
		rd_reg(8'h00, d);
		chk("alert status", d & 8'h20, 8'h20);
		wr_reg(8'h11, 8'h04);
		#1 chk("alert off", {6'h00, wake, intr}, 8'h02);
		@(posedge clk) alert_n <= 1'b1;
		wr_reg(8'h11, 8'h00);
		repeat (4) @(posedge clk);
		wr_reg(8'h00, 8'h20);
	endtask
	task automatic t_host;
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'h02, {7'h00, i[0]});
			wr_reg(8'h40, {6'h00, i[1], 1'b0});
			@(posedge clk) evt <= 4'h1 << i;
			@(posedge clk) evt <= 4'h0;
			#1 chk("host route", {6'h00, intr, hsmi}, {6'h00, i[0] & ~i[1], i[0] & i[1]});
			wr_reg(8'h00, 8'h1e);
		end
	endtask
	task automatic t_freeze;
		logic [7:0] d;
		@(posedge clk) ce <= 1'b0;
		wr_reg(8'h40, 8'h00);
		ce <= 1'b1;
		rd_reg(8'h40, d);
		chk("frozen write", d, 8'h02);
	endtask
	task automatic t_crc;
		logic [7:0] e, d;
		e = 8'h00;
		wr_reg(8'h05, 8'h5a);
		wr_reg(8'h0d, 8'h01);
		@(posedge clk) cclr <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			cclr <= 1'b0;
			cb <= 1'b1;
			cdata <= 8'h88 + k[7:0];
			e = crc8(e, 8'h88 + k[7:0]);
		end
		@(posedge clk);
		cb <= 1'b0;
		clast <= 1'b1;
		@(posedge clk) clast <= 1'b0;
		#1 chk("crc out", tbyte, e);
		chk("crc valid", {7'h00, tvalid}, 8'h01);
		for (int j = 0; j < 2; j++) begin
			@(posedge clk);
			cchk <= 1'b1;
			crx <= e ^ j[7:0];
			@(posedge clk) cchk <= 1'b0;
			rd_reg(8'h0c, d);
			chk("crc flags", d & 8'h05, j ? 8'h05 : 8'h00);
		end
	endtask
	task automatic link(input logic [23:0] f, input logic aw, sz, input logic [7:0] x, y);
		logic [2:0] a, s;
		logic [7:0] d, e;
		@(posedge clk);
		awake <= aw;
		s0 <= sz;
		fork
			smbevt_mcu_i.frame(f, 3, a);
			watch(s);
		join
		rd_reg(8'h12, d);
		rd_reg(8'h10, e);
		chk("link ack", {5'h00, a}, 8'h07);
		chk("link events", {5'h00, s}, x);
		chk("link status", {6'h00, e[0], d[0]}, y);
		chk("sda level", {7'h00, sda_o}, 8'h00);
		wr_reg(8'h12, 8'h01);
		wr_reg(8'h10, 8'h01);
	endtask
	task automatic t_link;
		logic [2:0] a;
		logic [7:0] d;
		wr_reg(8'h02, 8'h00);
		wr_reg(8'h40, 8'h00);
		link(24'h880001, 1'b1, 1'b1, 8'h01, 8'h01);
		link(24'h880001, 1'b0, 1'b1, 8'h04, 8'h01);
		link(24'h880008, 1'b1, 1'b0, 8'h00, 8'h01);
		link(24'h880008, 1'b1, 1'b1, 8'h01, 8'h01);
		wr_reg(8'h11, 8'h02);
		link(24'h103412, 1'b1, 1'b1, 8'h04, 8'h02);
		wr_reg(8'h11, 8'h01);
		link(24'h103412, 1'b1, 1'b1, 8'h02, 8'h02);
		wr_reg(8'h40, 8'h02);
		link(24'h103412, 1'b1, 1'b1, 8'h01, 8'h03);
		rd_reg(8'h0b, d);
		chk("notify data", d, 8'h12);
		rd_reg(8'h0a, d);
		chk("notify low", d, 8'h34);
		smbevt_mcu_i.frame(24'h8804a5, 3, a);
		rd_reg(8'h0a, d);
		chk("write data", d, 8'ha5);
		smbevt_mcu_i.frame(24'h89ff00, 2, a);
		chk("read ack", {7'h00, a[2]}, 8'h01);
		smbevt_mcu_i.frame(24'h8a0001, 3, a);
		chk("other addr", {5'h00, a}, 8'h00);
	endtask
	initial begin
		{ce, rst, wr, rd, cb, cclr, clast, cchk} = 8'hc0;
		{alert_n, awake, s0, evt} = 7'h70;
		{addr, wdata, cdata, crx} = 32'h0;
		n_errors = 0;
		compares = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_alert;
		t_host;
		t_freeze;
		t_crc;
		t_link;
		test_done;
	end
	initial begin
		#2000000;
		n_errors++;
		test_done;
	end
endmodule
`default_nettype wire

// file: tb/smbevt_mcu.sv
// Bus primary model for the external microcontroller
`timescale 1ns/1ps
`default_nettype none
module smbevt_mcu (
	input  wire logic sda_oe_in,
	output var  logic scl_out,
	output wire logic sda_line_out
);
	logic low_q;
	assign sda_line_out = !(low_q || sda_oe_in);
	initial begin
		scl_out = 1'b1;
		low_q = 1'b0;
	end
	task automatic bit_put(input logic b);
		low_q = !b;
		#50 scl_out = 1'b1;
		#100 scl_out = 1'b0;
		#50;
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) bit_put(b[i]);
		low_q = 1'b0;
		#50 scl_out = 1'b1;
		#50 ack = !sda_line_out;
		#50 scl_out = 1'b0;
		#50;
	endtask
	task automatic frame(input logic [23:0] f, input int n, output logic [2:0] a);
		#5;
		a = 3'b000;
		low_q = 1'b1;
		#100 scl_out = 1'b0;
		#50;
		for (int k = 0; k < n; k++) put_byte(f[23-8*k -: 8], a[2-k]);
		low_q = 1'b1;
		#50 scl_out = 1'b1;
		#100 low_q = 1'b0;
		#200;
	endtask
endmodule
`default_nettype wire

// file: tb/smbevt_props.sv
// Checker for the SMBus event block
`timescale 1ns/1ps
`default_nettype none
module smbevt_props (
	input wire logic       sys_clk_in,
	input wire logic       reset_in,
	input wire logic       clk_en_in,
	input wire logic       io_wr_in,
	input wire logic       io_rd_in,
	input wire logic [7:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic [7:0] io_rdata_out,
	input wire logic       alert_n_in,
	input wire logic [3:0] host_evt_in,
	input wire logic       crc_tx_last_in,
	input wire logic       crc_tx_valid_out,
	input wire logic       sda_oe_out,
	input wire logic       wake_out,
	input wire logic       intr_out,
	input wire logic       host_smi_out
);
	logic ien_q;
	logic sen_q;
	logic nen_q;
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ien_q <= 1'b0;
			sen_q <= 1'b0;
			nen_q <= 1'b0;
		end else if (io_wr_in && clk_en_in) begin
			if (io_addr_in == 8'h02) ien_q <= io_wdata_in[0];
			if (io_addr_in == 8'h40) sen_q <= io_wdata_in[1];
			if (io_addr_in == 8'h11) nen_q <= io_wdata_in[0];
		end
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	alert_wake_a: assert property ((!alert_n_in)[*5] |-> wake_out)
		else $error("alert low without wake");
	host_intr_a: assert property (host_evt_in != 4'h0 && ien_q && !sen_q |=> intr_out)
		else $error("host event without interrupt");
	host_smi_a: assert property (host_evt_in != 4'h0 && ien_q && sen_q |=> host_smi_out)
		else $error("host event without host smi");
	smi_gate_a: assert property (host_smi_out |-> ien_q && sen_q)
		else $error("host smi while not enabled");
	intr_gate_a: assert property (!ien_q && !nen_q |-> !intr_out)
		else $error("interrupt with enables off");
	crc_valid_a: assert property (crc_tx_last_in |=> crc_tx_valid_out ##1 !crc_tx_valid_out)
		else $error("crc byte not presented once");
	ack_only_a: assert property ($rose(sda_oe_out) |-> ##[1:10] !sda_oe_out)
		else $error("target drives data longer than one bit");
	rdata_hold_a: assert property (!io_rd_in |=> $stable(io_rdata_out))
		else $error("read data changed without read");
	cover property (host_smi_out);
	cover property (crc_tx_valid_out);
	cover property (wake_out && intr_out);
endmodule
bind smbevt_core smbevt_props smbevt_props_i (.sys_clk_in, .reset_in, .clk_en_in, .io_wr_in,
	.io_rd_in, .io_addr_in, .io_wdata_in, .io_rdata_out, .alert_n_in, .host_evt_in,
	.crc_tx_last_in, .crc_tx_valid_out, .sda_oe_out, .wake_out, .intr_out, .host_smi_out);
`default_nettype wire
